/* lmx_consts.svh */
`ifndef LMX_CONSTS_SVH
`define LMX_CONSTS_SVH
// Overview of operation
// RQ1: load bank literal puts 6-bit immediate into bank select, flags untouched.
// RQ2: load page literal puts 7-bit immediate into page latch, flags untouched.
// RQ3: load working literal puts 8-bit immediate into working register, flags untouched.
// RQ4: program image encodes don't-care bits of load working literal as zeros.
// RQ5: store working to file copies working register to addressed file; nothing else changes.
// RQ6: indirect store picks a pointer; address is pointer, pointer+1, pointer-1 or pointer+offset.
// RQ7: mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec; offset leaves pointer.
// RQ8: indirect ports hold nothing; accessing them reaches memory at the pointer.
// RQ9: pointers are 16 bits and wrap at both ends.
// RQ10: pointer updates never change status flags.
// RQ11: software reset resets the device and clears the reset-instruction flag.
// RQ12: return from interrupt pops the stack into the program counter.
// RQ13: return from interrupt sets global interrupt enable, bit 7 of interrupt control.
// RQ14: return from interrupt is one word and takes two cycles.
// RQ15: no-op takes one cycle and only advances the program counter.

// instruction words and prefixes
`define LMX_OP_NO_OP    14'h0000
`define LMX_OP_SWRST    14'h0001
`define LMX_OP_RETI     14'h0009
`define LMX_PFX_LDBANK  8'h05
`define LMX_PFX_LDPAGE  7'h63
`define LMX_PFX_LDWORK  6'h30
`define LMX_PFX_STFILE  7'h01
`define LMX_PFX_STIND   11'h003
`define LMX_PFX_STREL   7'h7f
`define LMX_MODE_PREINC 2'h0
`define LMX_MODE_PREDEC 2'h1
`define LMX_F_PORT0     7'h00
`define LMX_F_PORT1     7'h01

// register fields and reset values
`define LMX_ICR_ENA_BIT  3'h7
`define LMX_PWR_RSTI_BIT 3'h2
`define LMX_STAT_C       3'h0
`define LMX_STAT_Z       3'h2
`define LMX_RST_BYTE     8'h00
`define LMX_RST_PTR      16'h0000
`define LMX_RST_PROG     15'h0000
`define LMX_RST_BANK     6'h00
`define LMX_RST_PAGE     7'h00
`define LMX_RST_RSTI     1'b1

// apb byte offsets
`define LMX_A_WORK   8'h00
`define LMX_A_BANK   8'h04
`define LMX_A_PAGE   8'h08
`define LMX_A_PTR0   8'h0c
`define LMX_A_PTR1   8'h10
`define LMX_A_ICR    8'h14
`define LMX_A_PWR    8'h18
`define LMX_A_PROG   8'h1c
`define LMX_A_MADDR  8'h20
`define LMX_A_MDATA  8'h24
`define LMX_A_STAT   8'h28
`define LMX_A_CORE   8'h2c
`endif

/* lmx_exec.sv */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "lmx_consts.svh"
module lmx_exec #(
	parameter int MEM_AW    = 8,
	parameter int STK_DEPTH = 16
) (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [13:0] instr_in,
	input  wire logic        instr_valid_in,
	input  wire logic        push_in,
	input  wire logic [14:0] push_data_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic             instr_ready_out,
	output logic      [14:0] prog_ctr_out,
	output logic      [7:0]  work_out,
	output logic      [5:0]  bank_out,
	output logic      [6:0]  page_out,
	output logic             global_interrupt_enable_out,
	output logic             dev_reset_out
);
	lmx_pkg::lmx_op_t    op;
	lmx_pkg::lmx_state_t state;
	logic [7:0]  work;
	logic [5:0]  bank;
	logic [6:0]  page;
	logic [14:0] prog_ctr;
	logic        global_interrupt_enable;
	logic        rsti;
	logic [1:0]  stat;
	logic        ready;
	logic        srst;
	logic [7:0]  mem [2**MEM_AW];
	logic [15:0] maddr;
	logic [15:0] ptr0;
	logic [15:0] ptr1;
	logic [15:0] ea0;
	logic [15:0] ea1;
	logic [15:0] st_addr;
	logic [14:0] top_of_stack;
	logic [$clog2(STK_DEPTH)-1:0] level;
	logic        acc;
	logic        ind;
	logic        sel1;
	logic        upd0;
	logic        upd1;
	logic        mem_we;
	logic        apb_wr;
	logic        apb_rd;
	logic        hit;
	logic [31:0] rdata;

	assign acc    = instr_valid_in && ready;
	assign apb_wr = psel_in && penable_in && pready_out && pwrite_in;
	assign apb_rd = psel_in && penable_in && !pready_out;

	always_comb begin
		op = lmx_pkg::LMX_OP_NONE;
		if (acc) begin
			if (instr_in == `LMX_OP_NO_OP)
				op = lmx_pkg::LMX_OP_NO_OP;
			else if (instr_in == `LMX_OP_SWRST)
				op = lmx_pkg::LMX_OP_SWRST;
			else if (instr_in == `LMX_OP_RETI)
				op = lmx_pkg::LMX_OP_RETI;
			else if (instr_in[13:6] == `LMX_PFX_LDBANK)
				op = lmx_pkg::LMX_OP_LDBANK;
			else if (instr_in[13:7] == `LMX_PFX_LDPAGE)
				op = lmx_pkg::LMX_OP_LDPAGE;
			else if (instr_in[13:8] == `LMX_PFX_LDWORK)
				op = lmx_pkg::LMX_OP_LDWORK;
			else if (instr_in[13:7] == `LMX_PFX_STFILE)
				op = lmx_pkg::LMX_OP_STFILE;
			else if (instr_in[13:3] == `LMX_PFX_STIND)
				op = lmx_pkg::LMX_OP_STIND;
			else if (instr_in[13:7] == `LMX_PFX_STREL)
				op = lmx_pkg::LMX_OP_STREL;
			else
				op = lmx_pkg::LMX_OP_OTHER;
		end
	end

	// pointer select bit differs between the mode and offset forms
	assign ind  = (op == lmx_pkg::LMX_OP_STIND) || (op == lmx_pkg::LMX_OP_STREL);
	assign sel1 = (op == lmx_pkg::LMX_OP_STREL) ? instr_in[6] : instr_in[2];
	assign upd0 = ind && !sel1; // [RQ6]
	assign upd1 = ind && sel1; // [RQ6]

	lmx_ptr_unit #(.AW(16)) u_ptr0 (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.srst_in    (srst),
		.upd_in     (upd0),
		.rel_in     (op == lmx_pkg::LMX_OP_STREL),
		.mode_in    (instr_in[1:0]),
		.off_in     (instr_in[5:0]),
		.ld_in      (apb_wr && paddr_in == `LMX_A_PTR0),
		.ld_data_in (pwdata_in[15:0]),
		.ptr_out    (ptr0),
		.ea_out     (ea0)
	);

	lmx_ptr_unit #(.AW(16)) u_ptr1 (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.srst_in    (srst),
		.upd_in     (upd1),
		.rel_in     (op == lmx_pkg::LMX_OP_STREL),
		.mode_in    (instr_in[1:0]),
		.off_in     (instr_in[5:0]),
		.ld_in      (apb_wr && paddr_in == `LMX_A_PTR1),
		.ld_data_in (pwdata_in[15:0]),
		.ptr_out    (ptr1),
		.ea_out     (ea1)
	);

	lmx_ret_stack #(.DEPTH(STK_DEPTH), .DW(15)) u_stack (
		.ref_clk_in (ref_clk_in),
		.rst_n_in   (rst_n_in),
		.srst_in    (srst),
		.push_in    (push_in),
		.pop_in     (op == lmx_pkg::LMX_OP_RETI), // [RQ12]
		.data_in    (push_data_in),
		.top_of_stack_out (top_of_stack),
		.level_out  (level)
	);

	// store address; the two port addresses redirect through the pointers
	always_comb begin
		if (ind)
			st_addr = sel1 ? ea1 : ea0; // [RQ6]
		else if (instr_in[6:0] == `LMX_F_PORT0)
			st_addr = ptr0; // [RQ8]
		else if (instr_in[6:0] == `LMX_F_PORT1)
			st_addr = ptr1; // [RQ8]
		else
			st_addr = {3'h0, bank, instr_in[6:0]};
	end
	assign mem_we = ind || (op == lmx_pkg::LMX_OP_STFILE); // [RQ5]

	always_ff @(posedge ref_clk_in) begin
		if (mem_we)
			mem[st_addr[MEM_AW-1:0]] <= work; // [RQ5]
		else if (apb_wr && paddr_in == `LMX_A_MDATA)
			mem[maddr[MEM_AW-1:0]] <= pwdata_in[7:0];
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			maddr <= `LMX_RST_PTR;
		else if (apb_wr && paddr_in == `LMX_A_MADDR)
			maddr <= pwdata_in[15:0];
	end

	// instruction writes win over a same-cycle bus write
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			work <= `LMX_RST_BYTE;
		else if (srst)
			work <= `LMX_RST_BYTE;
		else if (op == lmx_pkg::LMX_OP_LDWORK)
			work <= instr_in[7:0]; // [RQ3]
		else if (apb_wr && paddr_in == `LMX_A_WORK)
			work <= pwdata_in[7:0];
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			bank <= `LMX_RST_BANK;
		else if (srst)
			bank <= `LMX_RST_BANK;
		else if (op == lmx_pkg::LMX_OP_LDBANK)
			bank <= instr_in[5:0]; // [RQ1]
		else if (apb_wr && paddr_in == `LMX_A_BANK)
			bank <= pwdata_in[5:0];
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			page <= `LMX_RST_PAGE;
		else if (srst)
			page <= `LMX_RST_PAGE;
		else if (op == lmx_pkg::LMX_OP_LDPAGE)
			page <= instr_in[6:0]; // [RQ2]
		else if (apb_wr && paddr_in == `LMX_A_PAGE)
			page <= pwdata_in[6:0];
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			global_interrupt_enable <= 1'b0;
		else if (srst)
			global_interrupt_enable <= 1'b0;
		else if (op == lmx_pkg::LMX_OP_RETI)
			global_interrupt_enable <= 1'b1; // [RQ13]
		else if (apb_wr && paddr_in == `LMX_A_ICR)
			global_interrupt_enable <= pwdata_in[`LMX_ICR_ENA_BIT];
	end

	// flag survives the soft reset so software can see the cause
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			rsti <= `LMX_RST_RSTI;
		else if (op == lmx_pkg::LMX_OP_SWRST)
			rsti <= 1'b0; // [RQ11]
		else if (apb_wr && paddr_in == `LMX_A_PWR)
			rsti <= pwdata_in[`LMX_PWR_RSTI_BIT];
	end

	// status flags only ever change from the bus
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			stat <= 2'h0;
		else if (apb_wr && paddr_in == `LMX_A_STAT)
			stat <= {pwdata_in[`LMX_STAT_Z], pwdata_in[`LMX_STAT_C]}; // [RQ10]
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state    <= lmx_pkg::LMX_ST_RUN;
			ready    <= 1'b1;
			srst     <= 1'b0;
			prog_ctr <= `LMX_RST_PROG;
		end else begin
			srst <= (op == lmx_pkg::LMX_OP_SWRST); // [RQ11]
			case (state)
				lmx_pkg::LMX_ST_RUN: begin
					if (op == lmx_pkg::LMX_OP_RETI) begin
						prog_ctr <= top_of_stack; // [RQ12]
						ready    <= 1'b0; // [RQ14]
						state    <= lmx_pkg::LMX_ST_RET2;
					end else if (op == lmx_pkg::LMX_OP_SWRST) begin
						ready <= 1'b0;
						state <= lmx_pkg::LMX_ST_RST;
					end else if (op != lmx_pkg::LMX_OP_NONE) begin
						prog_ctr <= 15'(prog_ctr + 15'h1); // [RQ15]
					end
				end
				lmx_pkg::LMX_ST_RET2: begin
					ready <= 1'b1; // [RQ14]
					state <= lmx_pkg::LMX_ST_RUN;
				end
				lmx_pkg::LMX_ST_RST: begin
					prog_ctr <= `LMX_RST_PROG; // [RQ11]
					ready    <= 1'b1;
					state    <= lmx_pkg::LMX_ST_RUN;
				end
				default: begin
					ready <= 1'b1;
					state <= lmx_pkg::LMX_ST_RUN;
				end
			endcase
		end
	end

	always_comb begin
		hit   = 1'b1;
		rdata = 32'h0;
		case (paddr_in)
			`LMX_A_WORK:  rdata = {24'h0, work};
			`LMX_A_BANK:  rdata = {26'h0, bank};
			`LMX_A_PAGE:  rdata = {25'h0, page};
			`LMX_A_PTR0:  rdata = {16'h0, ptr0};
			`LMX_A_PTR1:  rdata = {16'h0, ptr1};
			`LMX_A_ICR:   rdata = {24'h0, global_interrupt_enable, 7'h00};
			`LMX_A_PWR:   rdata = {29'h0, rsti, 2'h0};
			`LMX_A_PROG:  rdata = {17'h0, prog_ctr};
			`LMX_A_MADDR: rdata = {16'h0, maddr};
			`LMX_A_MDATA: rdata = {24'h0, mem[maddr[MEM_AW-1:0]]};
			`LMX_A_STAT:  rdata = {29'h0, stat[1], 1'b0, stat[0]};
			`LMX_A_CORE:  rdata = {24'h0, 4'(level), 2'h0, state};
			default:      hit = 1'b0;
		endcase
	end

	// one wait state: pready rises on the second access cycle
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_out  <= 1'b0;
			prdata_out  <= 32'h0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= apb_rd;
			pslverr_out <= apb_rd && !hit;
			prdata_out  <= (apb_rd && !pwrite_in) ? rdata : 32'h0;
		end
	end

	assign instr_ready_out = ready;
	assign prog_ctr_out    = prog_ctr;
	assign work_out        = work;
	assign bank_out        = bank;
	assign page_out        = page;
	assign global_interrupt_enable_out = global_interrupt_enable;
	assign dev_reset_out   = srst;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	ld_bank_a: assert property (op == lmx_pkg::LMX_OP_LDBANK && !apb_wr |=> bank == $past(instr_in[5:0]) // [RQ1]
		&& $stable(stat)) else $error("bank load wrong");
	ld_page_a: assert property (op == lmx_pkg::LMX_OP_LDPAGE |=> page == $past(instr_in[6:0])) // [RQ2]
		else $error("page load wrong");
	ld_work_a: assert property (op == lmx_pkg::LMX_OP_LDWORK |=> work == $past(instr_in[7:0])) // [RQ3]
		else $error("work load wrong");
	st_file_a: assert property (op == lmx_pkg::LMX_OP_STFILE && instr_in[6:1] != 6'h00 && !apb_wr // [RQ5]
		|=> mem[$past(st_addr[MEM_AW-1:0])] == $past(work) && $stable(work))
		else $error("file store wrong");
	port_redir_a: assert property (op == lmx_pkg::LMX_OP_STFILE && instr_in[6:0] == `LMX_F_PORT0 // [RQ8]
		|=> mem[$past(ptr0[MEM_AW-1:0])] == $past(work)) else $error("port store missed pointer");
	pre_inc_a: assert property (upd0 && op == lmx_pkg::LMX_OP_STIND // [RQ7]
		&& instr_in[1:0] == `LMX_MODE_PREINC
		|=> ptr0 == 16'($past(ptr0) + 16'h1) && mem[$past(ptr0[MEM_AW-1:0]) + 1'b1] == $past(work))
		else $error("pre-increment wrong");
	rel_hold_a: assert property (op == lmx_pkg::LMX_OP_STREL && !sel1 |=> $stable(ptr0)) // [RQ7]
		else $error("offset mode moved pointer");
	wrap_dec_a: assert property (upd1 && op == lmx_pkg::LMX_OP_STIND && instr_in[0] && ptr1 == 16'h0 // [RQ9]
		|=> ptr1 == 16'hffff) else $error("pointer did not wrap");
	flags_a: assert property (ind && !apb_wr |=> $stable(stat)) // [RQ10]
		else $error("indirect store touched flags");
	sw_reset_a: assert property (op == lmx_pkg::LMX_OP_SWRST |=> !rsti && dev_reset_out // [RQ11]
		##1 prog_ctr == 15'h0 && work == 8'h00) else $error("soft reset wrong");
	reti_a: assert property (op == lmx_pkg::LMX_OP_RETI |=> prog_ctr == $past(top_of_stack) // [RQ12]
		&& global_interrupt_enable) else $error("return wrong");
	reti_cyc_a: assert property (op == lmx_pkg::LMX_OP_RETI |=> !ready ##1 ready) // [RQ14]
		else $error("return not two cycles");
	no_op_a: assert property (op == lmx_pkg::LMX_OP_NO_OP && !apb_wr // [RQ15]
		|=> prog_ctr == 15'($past(prog_ctr) + 15'h1) && $stable(work) && $stable(bank) && $stable(page))
		else $error("no-op changed state");
endmodule : lmx_exec

/* lmx_pkg.sv */
package lmx_pkg;
	typedef enum logic [3:0] {
		LMX_OP_NONE   = 4'h0,
		LMX_OP_NO_OP  = 4'h1,
		LMX_OP_SWRST  = 4'h2,
		LMX_OP_RETI   = 4'h3,
		LMX_OP_LDBANK = 4'h4,
		LMX_OP_LDPAGE = 4'h5,
		LMX_OP_LDWORK = 4'h6,
		LMX_OP_STFILE = 4'h7,
		LMX_OP_STIND  = 4'h8,
		LMX_OP_STREL  = 4'h9,
		LMX_OP_OTHER  = 4'ha
	} lmx_op_t;
	typedef enum logic [1:0] {
		LMX_ST_RUN  = 2'h0,
		LMX_ST_RET2 = 2'h1,
		LMX_ST_RST  = 2'h2
	} lmx_state_t;
endpackage : lmx_pkg

/* lmx_ptr_unit.sv */
`timescale 1ns/1ps
`include "lmx_consts.svh"
module lmx_ptr_unit #(
	parameter int AW = 16
) (
	input  wire logic          ref_clk_in,
	input  wire logic          rst_n_in,
	input  wire logic          srst_in,
	input  wire logic          upd_in,
	input  wire logic          rel_in,
	input  wire logic [1:0]    mode_in,
	input  wire logic [5:0]    off_in,
	input  wire logic          ld_in,
	input  wire logic [AW-1:0] ld_data_in,
	output logic      [AW-1:0] ptr_out,
	output logic      [AW-1:0] ea_out
);
	logic [AW-1:0] inc;
	logic [AW-1:0] dec;
	logic [AW-1:0] next_ptr;

	// natural modulo arithmetic gives the wrap at both ends
	assign inc = AW'(ptr_out + AW'(1)); // [RQ9]
	assign dec = AW'(ptr_out - AW'(1)); // [RQ9]
	always_comb begin
		if (rel_in) begin
			ea_out   = AW'(ptr_out + {{(AW-6){off_in[5]}}, off_in}); // [RQ6]
			next_ptr = ptr_out; // [RQ7]
		end else begin
			next_ptr = mode_in[0] ? dec : inc; // [RQ7]
			ea_out   = mode_in[1] ? ptr_out : next_ptr; // [RQ6]
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			ptr_out <= `LMX_RST_PTR;
		else if (srst_in)
			ptr_out <= `LMX_RST_PTR;
		else if (upd_in)
			ptr_out <= next_ptr;
		else if (ld_in)
			ptr_out <= ld_data_in;
	end
endmodule : lmx_ptr_unit

/* lmx_ret_stack.sv */
`timescale 1ns/1ps
module lmx_ret_stack #(
	parameter int DEPTH = 16,
	parameter int DW    = 15
) (
	input  wire logic                     ref_clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic                     srst_in,
	input  wire logic                     push_in,
	input  wire logic                     pop_in,
	input  wire logic [DW-1:0]            data_in,
	output logic      [DW-1:0]            top_of_stack_out,
	output logic      [$clog2(DEPTH)-1:0] level_out
);
	localparam int IW = $clog2(DEPTH);
	logic [DW-1:0] slot [DEPTH];
	logic [IW-1:0] top_idx;

	// circular: overflow overwrites the oldest entry
	assign top_idx = IW'(level_out - IW'(1));
	assign top_of_stack_out = slot[top_idx];

	always_ff @(posedge ref_clk_in) begin
		if (push_in)
			slot[level_out] <= data_in;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			level_out <= '0;
		else if (srst_in)
			level_out <= '0;
		else if (push_in && !pop_in)
			level_out <= IW'(level_out + IW'(1));
		else if (pop_in && !push_in)
			level_out <= top_idx;
	end
endmodule : lmx_ret_stack

/* tb_top.sv */
`timescale 1ns/1ps
`include "lmx_consts.svh"
module tb_top;
	logic        ref_clk_in;
	logic        rst_n_in;
	logic [13:0] instr_in;
	logic        instr_valid_in;
	logic        push_in;
	logic [14:0] push_data_in;
	logic        psel_in;
	logic        penable_in;
	logic        pwrite_in;
	logic [7:0]  paddr_in;
	logic [31:0] pwdata_in;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        instr_ready_out;
	logic [14:0] prog_ctr_out;
	logic [7:0]  work_out;
	logic [5:0]  bank_out;
	logic [6:0]  page_out;
	logic        global_interrupt_enable_out;
	logic        dev_reset_out;
	int          errors;
	int          checked;

	lmx_exec lmx_exec_inst (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
		.instr_valid_in(instr_valid_in), .push_in(push_in), .push_data_in(push_data_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .instr_ready_out(instr_ready_out),
		.prog_ctr_out(prog_ctr_out), .work_out(work_out), .bank_out(bank_out),
		.page_out(page_out), .global_interrupt_enable_out(global_interrupt_enable_out),
		.dev_reset_out(dev_reset_out)
	);

	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
			output logic [31:0] rdata, output logic err);
		int n;
		n = 0;
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= addr;
		pwdata_in <= wdata;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		@(posedge ref_clk_in);
		while (pready_out !== 1'b1 && n < 20) begin
			n++;
			@(posedge ref_clk_in);
		end
		chk("apb answer", 32'h1, 32'(pready_out));
		rdata = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task automatic wr_reg(input logic [7:0] addr, input logic [31:0] data);
		logic [31:0] d;
		logic        e;
		apb(1'b1, addr, data, d, e);
		chk("write error", 32'h0, 32'(e));
	endtask : wr_reg

	task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] d;
		logic        e;
		apb(1'b0, addr, 32'h0, d, e);
		chk(what, exp, d);
		chk("read error", 32'h0, 32'(e));
	endtask : rd_chk

	task automatic mem_chk(input logic [7:0] idx, input logic [7:0] exp);
		wr_reg(`LMX_A_MADDR, {24'h0, idx});
		rd_chk("memory", `LMX_A_MDATA, {24'h0, exp});
	endtask : mem_chk

	// offer one word, return one step after the taking edge
	task automatic exec(input logic [13:0] w);
		@(posedge ref_clk_in);
		instr_valid_in <= 1'b1;
		instr_in <= w;
		@(posedge ref_clk_in);
		instr_valid_in <= 1'b0;
		#1;
	endtask : exec

	task automatic t_reset;
		logic [31:0] d;
		logic        e;
		chk("ready", 32'h1, 32'(instr_ready_out));
		chk("prog_ctr", 32'h0, 32'(prog_ctr_out));
		rd_chk("power control", `LMX_A_PWR, 32'h4);
		apb(1'b0, 8'hfc, 32'h0, d, e);
		chk("unmapped err", 32'h1, 32'(e));
		chk("unmapped data", 32'h0, d);
		$display("test reset done");
	endtask : t_reset

	task automatic t_literals;
		logic [14:0] start_ctr;
		wr_reg(`LMX_A_STAT, 32'h5);
		start_ctr = prog_ctr_out;
		exec({`LMX_PFX_LDBANK, 6'h3f});
		chk("bank", 32'h3f, 32'(bank_out));
		exec({`LMX_PFX_LDPAGE, 7'h7f});
		chk("page", 32'h7f, 32'(page_out));
		exec({`LMX_PFX_LDWORK, 8'ha5});
		chk("work", 32'ha5, 32'(work_out));
		chk("bank kept", 32'h3f, 32'(bank_out));
		exec({`LMX_PFX_LDBANK, 6'h00});
		chk("bank low", 32'h0, 32'(bank_out));
		chk("prog_ctr", 32'(start_ctr + 15'h4), 32'(prog_ctr_out));
		rd_chk("status", `LMX_A_STAT, 32'h5);
		$display("test literals done");
	endtask : t_literals

	task automatic t_stfile;
		exec({`LMX_PFX_LDWORK, 8'h4f});
		exec({`LMX_PFX_LDBANK, 6'h01});
		exec({`LMX_PFX_STFILE, 7'h23});
		chk("work kept", 32'h4f, 32'(work_out));
		mem_chk(8'ha3, 8'h4f);
		wr_reg(`LMX_A_PTR1, 32'h0042);
		exec({`LMX_PFX_STFILE, `LMX_F_PORT1});
		mem_chk(8'h42, 8'h4f);
		rd_chk("pointer1", `LMX_A_PTR1, 32'h0042);
		rd_chk("status", `LMX_A_STAT, 32'h5);
		$display("test store file done");
	endtask : t_stfile

	task automatic t_indirect;
		logic [15:0] st;
		logic [15:0] nx;
		logic [15:0] ea;
		for (int m = 0; m < 4; m++) begin
			st = m[0] ? 16'h0000 : 16'hffff;
			nx = m[0] ? st - 16'h1 : st + 16'h1;
			ea = m[1] ? st : nx;
			wr_reg(m[1] ? `LMX_A_PTR1 : `LMX_A_PTR0, {16'h0, st});
			exec({`LMX_PFX_LDWORK, 8'(8'h10 + m)});
			exec({`LMX_PFX_STIND, m[1], 2'(m)});
			mem_chk(ea[7:0], 8'(8'h10 + m));
			rd_chk("pointer", m[1] ? `LMX_A_PTR1 : `LMX_A_PTR0, {16'h0, nx});
		end
		wr_reg(`LMX_A_PTR0, 32'h0010);
		exec({`LMX_PFX_STREL, 1'b0, 6'h20});
		mem_chk(8'hf0, 8'h13);
		rd_chk("pointer0", `LMX_A_PTR0, 32'h0010);
		wr_reg(`LMX_A_PTR1, 32'hfff0);
		exec({`LMX_PFX_STREL, 1'b1, 6'h1f});
		mem_chk(8'h0f, 8'h13);
		rd_chk("status", `LMX_A_STAT, 32'h5);
		$display("test indirect done");
	endtask : t_indirect

	task automatic t_reti;
		wr_reg(`LMX_A_ICR, 32'h0);
		@(posedge ref_clk_in);
		push_in <= 1'b1;
		push_data_in <= 15'h1234;
		@(posedge ref_clk_in);
		push_data_in <= 15'h0abc;
		@(posedge ref_clk_in);
		push_in <= 1'b0;
		exec(`LMX_OP_RETI);
		chk("prog_ctr", 32'h0abc, 32'(prog_ctr_out));
		chk("int enable", 32'h1, 32'(global_interrupt_enable_out));
		chk("ready busy", 32'h0, 32'(instr_ready_out));
		@(posedge ref_clk_in);
		#1;
		chk("ready again", 32'h1, 32'(instr_ready_out));
		rd_chk("interrupt control", `LMX_A_ICR, 32'h80);
		rd_chk("core level", `LMX_A_CORE, 32'h10);
		exec(`LMX_OP_RETI);
		chk("prog_ctr", 32'h1234, 32'(prog_ctr_out));
		@(posedge ref_clk_in);
		$display("test return done");
	endtask : t_reti

	task automatic t_nop;
		logic [14:0] start_ctr;
		logic [7:0]  w;
		start_ctr = prog_ctr_out;
		w = work_out;
		exec(`LMX_OP_NO_OP);
		chk("prog_ctr", 32'(start_ctr + 15'h1), 32'(prog_ctr_out));
		chk("work", 32'(w), 32'(work_out));
		chk("bank", 32'h01, 32'(bank_out));
		chk("page", 32'h7f, 32'(page_out));
		chk("ready", 32'h1, 32'(instr_ready_out));
		rd_chk("status", `LMX_A_STAT, 32'h5);
		exec(14'h0002);
		chk("other prog_ctr", 32'(start_ctr + 15'h2), 32'(prog_ctr_out));
		chk("other work", 32'(w), 32'(work_out));
		$display("test no-op done");
	endtask : t_nop

	task automatic t_swrst;
		wr_reg(`LMX_A_PTR0, 32'h1234);
		exec(`LMX_OP_SWRST);
		chk("reset pulse", 32'h1, 32'(dev_reset_out));
		chk("ready busy", 32'h0, 32'(instr_ready_out));
		@(posedge ref_clk_in);
		#1;
		chk("reset pulse end", 32'h0, 32'(dev_reset_out));
		chk("prog_ctr", 32'h0, 32'(prog_ctr_out));
		chk("work", 32'h0, 32'(work_out));
		chk("ready", 32'h1, 32'(instr_ready_out));
		rd_chk("power control", `LMX_A_PWR, 32'h0);
		rd_chk("pointer0", `LMX_A_PTR0, 32'h0);
		rd_chk("status kept", `LMX_A_STAT, 32'h5);
		$display("test soft reset done");
	endtask : t_swrst

	task automatic end_of_test;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	initial begin
		#60000;
		errors++;
		end_of_test();
	end

	initial begin
		errors = 0;
		checked = 0;
		rst_n_in = 1'b0;
		instr_in = 14'h0;
		instr_valid_in = 1'b0;
		push_in = 1'b0;
		push_data_in = 15'h0;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 8'h0;
		pwdata_in = 32'h0;
		repeat (20) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		@(posedge ref_clk_in);
		#1;
		t_reset();
		t_literals();
		t_stfile();
		t_indirect();
		t_reti();
		t_nop();
		t_swrst();
		end_of_test();
	end
endmodule : tb_top
